/* bbr_mem_model.sv */
`timescale 1ns/1ps
module bbr_mem_model
  import bbr_pkg::*;
(
  input wire logic clk,
  input wire logic dn_valid,
  input wire bbr_dn_req_t dn_req,
  output logic dn_ready,
  output logic dn_rvalid,
  output logic [31:0] dn_rdata,
  output logic dn_rerr,
  input wire logic [3:0] lat,
  input wire logic fail_rd
);
  logic [31:0] mem [logic [29:0]];
  initial begin
    bbr_dn_req_t r;
    logic [31:0] w;
    dn_ready = 1'h0;
    dn_rvalid = 1'h0;
    dn_rdata = 32'h5A5A_5A5A;
    dn_rerr = 1'h0;
    forever begin
      @(posedge clk);
      #1;
      if (dn_valid) begin
        repeat (lat) @(posedge clk);
        if (lat != 4'h0) #1;
        dn_ready = 1'h1;
        @(posedge clk);
        r = dn_req;
        #1;
        dn_ready = 1'h0;
        w = mem.exists(r.addr[31:2]) ? mem[r.addr[31:2]] : 32'h0;
        for (int b = 0; b < 4; b++) begin
          if (r.write && (r.size == BBR_SIZE_WORD || (b[1] == r.addr[1] &&
              (r.size == BBR_SIZE_HALF || b[0] == r.addr[0])))) begin
            w[8*b+:8] = r.wdata[8*b+:8];
          end
        end
        if (r.write) mem[r.addr[31:2]] = w;
        repeat (lat) @(posedge clk);
        if (lat != 4'h0) #1;
        dn_rvalid = 1'h1;
        // Write answers carry junk so nobody relies on them
        dn_rdata = r.write ? ~w : w;
        dn_rerr = fail_rd && !r.write;
        @(posedge clk);
        #1;
        dn_rvalid = 1'h0;
        dn_rdata = ~dn_rdata;
        dn_rerr = 1'h0;
      end
    end
  end
endmodule

/* bbr_pkg.sv */
package bbr_pkg;

  // Alias windows and the bit-band regions they reach
  localparam logic [31:0] BBR_SRAM_ALIAS_BASE = 32'h2200_0000;
  localparam logic [31:0] BBR_SRAM_ALIAS_LAST = 32'h221F_FFFF;
  localparam logic [31:0] BBR_SRAM_BAND_BASE = 32'h2000_0000;
  localparam logic [31:0] BBR_SRAM_BAND_LAST = 32'h2000_FFFF;
  localparam logic [31:0] BBR_PERI_ALIAS_BASE = 32'h4200_0000;
  localparam logic [31:0] BBR_PERI_ALIAS_LAST = 32'h43FF_FFFF;
  localparam logic [31:0] BBR_PERI_BAND_BASE = 32'h4000_0000;
  localparam logic [31:0] BBR_PERI_BAND_LAST = 32'h400F_FFFF;
  // Each band byte spans 32 alias bytes, each bit 4 alias bytes
  localparam int BBR_BYTE_SHIFT = 5;
  localparam int BBR_BIT_LSB = 2;

  // Access sizes
  localparam logic [1:0] BBR_SIZE_BYTE = 2'h0;
  localparam logic [1:0] BBR_SIZE_HALF = 2'h1;
  localparam logic [1:0] BBR_SIZE_WORD = 2'h2;

  localparam logic BBR_UP_READY_RST = 1'h1;

  typedef struct packed {
    logic fetch;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bbr_up_req_t;

  typedef struct packed {
    logic write;
    logic lock;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } bbr_dn_req_t;

  typedef enum logic [2:0] {
    BBR_IDLE = 3'h0,
    BBR_ISSUE = 3'h1,
    BBR_WAIT = 3'h3,
    BBR_WR_ISSUE = 3'h2,
    BBR_WR_WAIT = 3'h6
  } bbr_state_t;

  typedef enum logic [1:0] {
    BBR_CL_PASS = 2'h0,
    BBR_CL_SRAM = 2'h1,
    BBR_CL_PERI = 2'h2,
    BBR_CL_REFUSE = 2'h3
  } bbr_class_t;

  typedef enum logic [1:0] {
    BBR_OP_PASS = 2'h0,
    BBR_OP_ALIAS_RD = 2'h1,
    BBR_OP_RMW = 2'h2
  } bbr_op_t;

  function automatic bbr_class_t bbr_classify(input logic [31:0] addr,
                                              input logic fetch,
                                              input logic [1:0] size);
    bbr_class_t cls;
    cls = BBR_CL_PASS;
    if (size > BBR_SIZE_WORD) begin
      cls = BBR_CL_REFUSE;
    end else if (addr >= BBR_PERI_ALIAS_BASE &&
                 addr <= BBR_PERI_ALIAS_LAST) begin
      cls = fetch ? BBR_CL_REFUSE : BBR_CL_PERI;
    end else if (addr >= BBR_SRAM_ALIAS_BASE &&
                 addr <= BBR_SRAM_ALIAS_LAST && !fetch) begin
      cls = BBR_CL_SRAM;
    end
    return cls;
  endfunction

  // Byte address in the band that holds the aliased bit
  function automatic logic [31:0] bbr_band_byte(input logic [31:0] addr,
                                                input logic peri);
    logic [31:0] off;
    off = addr - (peri ? BBR_PERI_ALIAS_BASE : BBR_SRAM_ALIAS_BASE);
    return (peri ? BBR_PERI_BAND_BASE : BBR_SRAM_BAND_BASE) +
           (off >> BBR_BYTE_SHIFT);
  endfunction

  // Align the band byte to the original access size
  function automatic logic [31:0] bbr_align(input logic [31:0] addr,
                                            input logic [1:0] size);
    logic [31:0] a;
    a = addr;
    if (size == BBR_SIZE_HALF) a[0] = 1'b0;
    if (size == BBR_SIZE_WORD) a[1:0] = 2'h0;
    return a;
  endfunction

  // Little-endian lane: bit position on the 32-bit data bus
  function automatic logic [4:0] bbr_bit_pos(input logic [31:0] addr,
                                             input logic peri);
    logic [31:0] band;
    band = bbr_band_byte(addr, peri);
    return {band[1:0], addr[BBR_BIT_LSB+2:BBR_BIT_LSB]};
  endfunction

endpackage

/* bbr_remapper.sv */
`timescale 1ns/1ps
// Behaviour
// - Each alias word stands for exactly one bit of its bit-band region.
// - The bit-band regions sit at the bottom 64 KB of SRAM and the bottom 1 MB of peripheral space.
// - Data accesses to 0x2200_0000-0x221F_FFFF become bit accesses at 0x2000_0000-0x2000_FFFF.
// - Data accesses to 0x4200_0000-0x43FF_FFFF become bit accesses at 0x4000_0000-0x400F_FFFF.
// - The downstream access keeps the size of the original alias access.
// - An alias write is a read, a change of the one bit, and a write-back.
// - Fetches into the SRAM alias window are passed on untranslated.
// - Fetches into the peripheral alias window are refused.
// - Alias offset is band byte offset times 32 plus bit index times 4.
// - The bit index taken from an alias address runs from zero to seven.
// - Bit 0 of alias write data becomes the new value of the target bit.
// - Alias write data bits 31 to 1 are ignored.
// - An alias read returns 0 or 1 in bit 0 with all other bits zero.
// - Direct accesses to the bit-band ranges pass on unchanged.
// - Memory is byte addressed and little-endian on the 32-bit data bus.
module bbr_remapper
  import bbr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic up_valid,
  input wire bbr_up_req_t up_req,
  output logic up_ready,
  output logic up_rvalid,
  output logic [31:0] up_rdata,
  output logic up_rerr,
  output logic dn_valid,
  output bbr_dn_req_t dn_req,
  input wire logic dn_ready,
  input wire logic dn_rvalid,
  input wire logic [31:0] dn_rdata,
  input wire logic dn_rerr
);

  bbr_state_t state_reg, state_next;
  bbr_op_t op_reg, op_next;
  bbr_dn_req_t dn_req_reg, dn_req_next;
  logic dn_valid_reg, dn_valid_next;
  logic up_ready_reg, up_ready_next;
  logic up_rvalid_reg, up_rvalid_next;
  logic up_rerr_reg, up_rerr_next;
  logic [31:0] up_rdata_reg, up_rdata_next;
  logic [4:0] bit_pos_reg, bit_pos_next;
  logic wbit_reg, wbit_next;

  logic accept;
  bbr_class_t cls;
  logic peri;
  logic [31:0] merged;

  assign accept = up_valid && up_ready_reg;
  assign cls = bbr_classify(up_req.addr, up_req.fetch, up_req.size);
  assign peri = (cls == BBR_CL_PERI);
  assign merged = (dn_rdata & ~(32'h0000_0001 << bit_pos_reg)) |
                  ({31'h0, wbit_reg} << bit_pos_reg);

  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    dn_req_next = dn_req_reg;
    dn_valid_next = dn_valid_reg;
    up_rvalid_next = 1'b0;
    up_rerr_next = 1'b0;
    up_rdata_next = up_rdata_reg;
    bit_pos_next = bit_pos_reg;
    wbit_next = wbit_reg;
    case (state_reg)
      BBR_IDLE: begin
        if (accept) begin
          case (cls)
            BBR_CL_REFUSE: begin
              up_rvalid_next = 1'b1;
              up_rerr_next = 1'b1;
              up_rdata_next = 32'h0000_0000;
            end
            BBR_CL_SRAM, BBR_CL_PERI: begin
              dn_req_next.write = 1'b0;
              dn_req_next.lock = up_req.write;
              dn_req_next.size = up_req.size;
              dn_req_next.addr = bbr_align(bbr_band_byte(up_req.addr, peri),
                                           up_req.size);
              dn_req_next.wdata = 32'h0000_0000;
              bit_pos_next = bbr_bit_pos(up_req.addr, peri);
              wbit_next = up_req.wdata[0];
              op_next = up_req.write ? BBR_OP_RMW : BBR_OP_ALIAS_RD;
              dn_valid_next = 1'b1;
              state_next = BBR_ISSUE;
            end
            default: begin
              dn_req_next.write = up_req.write;
              dn_req_next.lock = 1'b0;
              dn_req_next.size = up_req.size;
              dn_req_next.addr = up_req.addr;
              dn_req_next.wdata = up_req.wdata;
              op_next = BBR_OP_PASS;
              dn_valid_next = 1'b1;
              state_next = BBR_ISSUE;
            end
          endcase
        end
      end
      BBR_ISSUE: begin
        if (dn_ready) begin
          dn_valid_next = 1'b0;
          state_next = BBR_WAIT;
        end
      end
      BBR_WAIT: begin
        if (dn_rvalid) begin
          if (op_reg == BBR_OP_RMW && !dn_rerr) begin
            dn_req_next.write = 1'b1;
            dn_req_next.wdata = merged;
            dn_valid_next = 1'b1;
            state_next = BBR_WR_ISSUE;
          end else begin
            up_rvalid_next = 1'b1;
            up_rerr_next = dn_rerr;
            dn_req_next.lock = 1'b0;
            state_next = BBR_IDLE;
            case (op_reg)
              BBR_OP_ALIAS_RD: up_rdata_next = {31'h0, dn_rdata[bit_pos_reg]};
              BBR_OP_RMW: up_rdata_next = 32'h0000_0000;
              default: up_rdata_next = dn_rdata;
            endcase
          end
        end
      end
      BBR_WR_ISSUE: begin
        if (dn_ready) begin
          dn_valid_next = 1'b0;
          state_next = BBR_WR_WAIT;
        end
      end
      BBR_WR_WAIT: begin
        if (dn_rvalid) begin
          up_rvalid_next = 1'b1;
          up_rerr_next = dn_rerr;
          up_rdata_next = 32'h0000_0000;
          dn_req_next.lock = 1'b0;
          state_next = BBR_IDLE;
        end
      end
      default: begin
        state_next = BBR_IDLE;
        dn_valid_next = 1'b0;
        dn_req_next.lock = 1'b0;
      end
    endcase
    up_ready_next = (state_next == BBR_IDLE);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= BBR_IDLE;
      op_reg <= BBR_OP_PASS;
      dn_req_reg <= '0;
      dn_valid_reg <= 1'b0;
      up_ready_reg <= BBR_UP_READY_RST;
      up_rvalid_reg <= 1'b0;
      up_rerr_reg <= 1'b0;
      up_rdata_reg <= 32'h0000_0000;
      bit_pos_reg <= 5'h00;
      wbit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      dn_req_reg <= dn_req_next;
      dn_valid_reg <= dn_valid_next;
      up_ready_reg <= up_ready_next;
      up_rvalid_reg <= up_rvalid_next;
      up_rerr_reg <= up_rerr_next;
      up_rdata_reg <= up_rdata_next;
      bit_pos_reg <= bit_pos_next;
      wbit_reg <= wbit_next;
    end
  end

  assign up_ready = up_ready_reg;
  assign up_rvalid = up_rvalid_reg;
  assign up_rdata = up_rdata_reg;
  assign up_rerr = up_rerr_reg;
  assign dn_valid = dn_valid_reg;
  assign dn_req = dn_req_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_acc_sram;
    accept && cls == BBR_CL_SRAM;
  endsequence

  sequence s_acc_alias_wr;
    accept && (cls == BBR_CL_SRAM || cls == BBR_CL_PERI) && up_req.write;
  endsequence

  sequence s_rmw_read_ok;
    state_reg == BBR_WAIT && dn_rvalid && !dn_rerr && op_reg == BBR_OP_RMW;
  endsequence

  property p_fetch_refused;
    accept && up_req.fetch && up_req.size <= BBR_SIZE_WORD &&
      up_req.addr >= BBR_PERI_ALIAS_BASE &&
      up_req.addr <= BBR_PERI_ALIAS_LAST
      |=> up_rvalid && up_rerr && !dn_valid;
  endproperty
  a_fetch_refused: assert property (p_fetch_refused)
    else $error("peripheral alias fetch not refused");

  property p_sram_remap;
    s_acc_sram |=> dn_valid && !dn_req.write &&
      dn_req.addr == bbr_align(BBR_SRAM_BAND_BASE +
        (($past(up_req.addr) - BBR_SRAM_ALIAS_BASE) >> BBR_BYTE_SHIFT),
        $past(up_req.size));
  endproperty
  a_sram_remap: assert property (p_sram_remap)
    else $error("SRAM alias address remapped wrongly");

  property p_peri_band;
    accept && cls == BBR_CL_PERI |=>
      dn_req.addr >= BBR_PERI_BAND_BASE &&
      dn_req.addr <= BBR_PERI_BAND_LAST;
  endproperty
  a_peri_band: assert property (p_peri_band)
    else $error("peripheral alias left the band region");

  property p_size_kept;
    accept && cls != BBR_CL_REFUSE |=> dn_req.size == $past(up_req.size);
  endproperty
  a_size_kept: assert property (p_size_kept)
    else $error("downstream size differs from request");

  property p_rmw_starts_read;
    s_acc_alias_wr |=> dn_valid && !dn_req.write && dn_req.lock;
  endproperty
  a_rmw_starts_read: assert property (p_rmw_starts_read)
    else $error("alias write did not begin with a read");

  property p_rmw_locked_write;
    s_rmw_read_ok |=> dn_valid && dn_req.write && dn_req.lock &&
      $stable(dn_req.addr) && $stable(dn_req.size);
  endproperty
  a_rmw_locked_write: assert property (p_rmw_locked_write)
    else $error("write-back not locked to its read");

  property p_bit_merge;
    s_rmw_read_ok |=>
      ((dn_req.wdata ^ $past(dn_rdata)) & ~(32'h0000_0001 << bit_pos_reg))
        == 32'h0000_0000 &&
      dn_req.wdata[bit_pos_reg] == wbit_reg;
  endproperty
  a_bit_merge: assert property (p_bit_merge)
    else $error("write-back changed more than the target bit");

  property p_read_zero_or_one;
    state_reg == BBR_WAIT && dn_rvalid && op_reg == BBR_OP_ALIAS_RD
      |=> up_rvalid && up_rdata[31:1] == 31'h0 &&
          up_rdata[0] == $past(dn_rdata[bit_pos_reg]);
  endproperty
  a_read_zero_or_one: assert property (p_read_zero_or_one)
    else $error("alias read returned a wrong value");

  property p_pass_through;
    accept && cls == BBR_CL_PASS |=> dn_valid && !dn_req.lock &&
      dn_req.addr == $past(up_req.addr) &&
      dn_req.wdata == $past(up_req.wdata) &&
      dn_req.write == $past(up_req.write);
  endproperty
  a_pass_through: assert property (p_pass_through)
    else $error("pass-through access was modified");

  property p_sram_band;
    s_acc_sram |=>
      dn_req.addr >= BBR_SRAM_BAND_BASE &&
      dn_req.addr <= BBR_SRAM_BAND_LAST;
  endproperty
  a_sram_band: assert property (p_sram_band)
    else $error("SRAM alias left the band region");

  property p_peri_remap;
    accept && cls == BBR_CL_PERI |=> dn_valid && !dn_req.write &&
      dn_req.addr == bbr_align(BBR_PERI_BAND_BASE +
        (($past(up_req.addr) - BBR_PERI_ALIAS_BASE) >> BBR_BYTE_SHIFT),
        $past(up_req.size));
  endproperty
  a_peri_remap: assert property (p_peri_remap)
    else $error("peripheral alias address remapped wrongly");

  property p_sram_fetch_pass;
    accept && up_req.fetch && up_req.size <= BBR_SIZE_WORD &&
      up_req.addr >= BBR_SRAM_ALIAS_BASE &&
      up_req.addr <= BBR_SRAM_ALIAS_LAST
      |=> dn_valid && !dn_req.lock && dn_req.addr == $past(up_req.addr);
  endproperty
  a_sram_fetch_pass: assert property (p_sram_fetch_pass)
    else $error("SRAM alias fetch was translated");

  // Slow slaves may sample late, so the request must not move
  property p_dn_held;
    dn_valid && !dn_ready |=> dn_valid && $stable(dn_req);
  endproperty
  a_dn_held: assert property (p_dn_held)
    else $error("downstream request changed before it was taken");

  sequence s_rmw_read_fail;
    state_reg == BBR_WAIT && dn_rvalid && dn_rerr && op_reg == BBR_OP_RMW;
  endsequence

  // A failed read leaves memory alone: no write-back
  property p_rmw_read_fail;
    s_rmw_read_fail |=> up_rvalid && up_rerr && !dn_valid && !dn_req.lock;
  endproperty
  a_rmw_read_fail: assert property (p_rmw_read_fail)
    else $error("alias write went on after a failed read");

  property p_wb_done;
    state_reg == BBR_WR_WAIT && dn_rvalid |=> up_rvalid && up_ready &&
      up_rdata == 32'h0000_0000 && !dn_req.lock;
  endproperty
  a_wb_done: assert property (p_wb_done)
    else $error("lock not released after the write-back");

endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench import bbr_pkg::*;;
  typedef struct {
    logic f, w; logic [1:0] sz; logic [31:0] a, wd, pre, ea;
    logic [1:0] es; logic [31:0] rd; logic er; int n; logic [31:0] em;
  } bbr_tb_row_t;
  logic clk, arst_n, up_valid, up_ready, up_rvalid, up_rerr;
  logic dn_valid, dn_ready, dn_rvalid, dn_rerr, fail_rd, got_er;
  logic [31:0] up_rdata, dn_rdata, got_rd;
  logic [3:0] lat;
  bbr_up_req_t up_req;
  bbr_dn_req_t dn_req;
  bbr_dn_req_t dnq [$];
  int errors, check_count;
  bbr_tb_row_t rows [11] = '{
    '{0,0,2,32'h2200_001C,0,32'h80,32'h2000_0000,2,1,0,1,32'h80},
    '{0,0,0,32'h221F_FFFC,0,32'h7FFF_FFFF,32'h2000_FFFF,0,0,0,1,
      32'h7FFF_FFFF},
    '{0,1,0,32'h4200_0004,32'hFF,0,32'h4000_0000,0,0,0,2,32'h2},
    '{0,1,1,32'h43FF_FFE4,32'hE,32'hFFFF_FFFF,32'h400F_FFFE,1,0,0,2,
      32'hFDFF_FFFF},
    '{0,1,2,32'h2200_0000,1,0,32'h2000_0000,2,0,0,2,1},
    '{0,0,2,32'h2000_0004,0,32'h1234_5678,32'h2000_0004,2,32'h1234_5678,
      0,1,32'h1234_5678},
    '{1,0,2,32'h2200_0010,0,32'hA5,32'h2200_0010,2,32'hA5,0,1,32'hA5},
    '{1,0,2,32'h4200_0000,0,0,0,0,0,1,0,0},
    '{0,0,3,32'h6000_0000,0,0,0,0,0,1,0,0},
    '{0,1,2,32'h6000_0008,32'hCAFE_F00D,0,32'h6000_0008,2,32'h3501_0FF2,0,1,
      32'hCAFE_F00D},
    '{0,0,1,32'h4200_003C,0,32'h8000,32'h4000_0000,1,1,0,1,32'h8000}};

  bbr_remapper u_bbr_remapper (.clk(clk), .arst_n(arst_n),
    .up_valid(up_valid), .up_req(up_req), .up_ready(up_ready),
    .up_rvalid(up_rvalid), .up_rdata(up_rdata), .up_rerr(up_rerr),
    .dn_valid(dn_valid), .dn_req(dn_req), .dn_ready(dn_ready),
    .dn_rvalid(dn_rvalid), .dn_rdata(dn_rdata), .dn_rerr(dn_rerr));
  bbr_mem_model u_bbr_mem_model (.clk(clk), .dn_valid(dn_valid),
    .dn_req(dn_req), .dn_ready(dn_ready), .dn_rvalid(dn_rvalid),
    .dn_rdata(dn_rdata), .dn_rerr(dn_rerr), .lat(lat), .fail_rd(fail_rd));

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (dn_valid && dn_ready) dnq.push_back(dn_req);
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic req(input logic f, w, input logic [1:0] sz,
                     input logic [31:0] a, wd);
    int n;
    up_req = '{fetch: f, write: w, size: sz, addr: a, wdata: wd};
    up_valid = 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (up_ready !== 1'h1 && n < 50);
    #1;
    up_valid = 1'h0;
    n = 0;
    while (up_rvalid !== 1'h1 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (up_rvalid !== 1'h1) begin
      $display("timeout at %0t", $time);
      errors++;
      stop_test();
    end else begin
      got_rd = up_rdata;
      got_er = up_rerr;
      @(posedge clk);
      #1;
    end
  endtask

  initial begin
    bbr_tb_row_t t;
    arst_n = 1'h0;
    up_valid = 1'h0;
    up_req = '0;
    lat = 4'h0;
    fail_rd = 1'h0;
    errors = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'h1;
    check({28'h0, up_ready, dn_valid, up_rvalid, dn_req.lock}, 32'h8);
    // A slow far side on the second pass
    for (int p = 0; p < 2; p++) begin
      lat = p ? 4'h3 : 4'h0;
      foreach (rows[i]) begin
        t = rows[i];
        u_bbr_mem_model.mem.delete();
        u_bbr_mem_model.mem[t.ea[31:2]] = t.pre;
        dnq.delete();
        req(t.f, t.w, t.sz, t.a, t.wd);
        check(got_rd, t.rd);
        check({31'h0, got_er}, {31'h0, t.er});
        check(32'(dnq.size()), 32'(t.n));
        if (t.n > 0) begin
          check(dnq[0].addr, t.ea);
          check({30'h0, dnq[0].size}, {30'h0, t.es});
          check({30'h0, dnq[0].write, dnq[0].lock},
                {30'h0, t.w && t.n == 1, t.n == 2});
          check(u_bbr_mem_model.mem[t.ea[31:2]], t.em);
        end
        if (t.n == 2) begin
          check({dnq[1].addr[29:0], dnq[1].write, dnq[1].lock},
                {t.ea[29:0], 2'h3});
        end
      end
    end
    // Reset between requests; the next one is taken at the first edge
    @(posedge clk);
    #1;
    arst_n = 1'h0;
    #1;
    check({28'h0, up_ready, dn_valid, up_rvalid, dn_req.lock}, 32'h8);
    check(up_rdata, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    arst_n = 1'h1;
    lat = 4'h1;
    fail_rd = 1'h1;
    u_bbr_mem_model.mem.delete();
    u_bbr_mem_model.mem[30'h0800_0000] = 32'h0;
    dnq.delete();
    req(1'h0, 1'h1, BBR_SIZE_WORD, 32'h2200_0004, 32'h1);
    fail_rd = 1'h0;
    check({31'h0, got_er}, 32'h1);
    check(32'(dnq.size()), 32'h1);
    check(u_bbr_mem_model.mem[30'h0800_0000], 32'h0);
    // Set every bit of band byte 1 one by one
    for (int i = 0; i < 8; i++) begin
      req(1'h0, 1'h1, BBR_SIZE_BYTE, 32'h2200_0020 + 32'(4 * i), 32'h1);
    end
    check(u_bbr_mem_model.mem[30'h0800_0000], 32'h0000_FF00);
    stop_test();
  end
endmodule
